// ### rtl/timer_bypass_top.sv
`timescale 1ns/10ps
//////////////////////////////////////////////////////////////////////////////
// How it works
// (RQ1) mode 111 holds counter and prescaler disabled; pins act as i/o.
// (RQ2) bypass, clock enable, bit 13 clear: running flag follows asserted gate.
// (RQ3) gate_level always shows the gate pin level.
// (RQ4) bypass with bit 13, gate enable, clock enable: gate negation sets flag, irq.
// (RQ5) gate_event_flag clears only by writing one; zero leaves it.
// (RQ6) simple output changes only while soft_reset_release is zero.
// (RQ7) output_control 00 hi-z, 01 and 10 low, 11 high.
// (RQ8) status reads timeout, compare flags zero and prescaler all ones.
// (RQ9) output_level shows the actual timer_output pin level.
// (RQ10) reads of any size finish with no wait, 16 valid bits.
// (RQ11) reserved locations read as zero.
// (RQ12) writes finish with no wait; read-only or reserved data dropped.
// (RQ13) acknowledge cycle: arbitrate and drive the stored vector on winning.
// (RQ14) software must load the vector register before interrupts are served.
// (RQ15) instances decode at base plus 0x600 and 0x640.
// (RQ16) supervisor-only always; supervisor/user gated by user_access_lock.
// (RQ17) reset instruction resets all registers except module_config_reg.
// (RQ18) module_stop halts all timer clocks except the bus clock.
// (RQ19) while stopped, non-config accesses end with a bus error.
// (RQ20) software disables the timer before setting module_stop.
// (RQ21) debug_halt with freeze_action 1x freezes; 0x ignores.
// (RQ22) arbitration id 0xF highest, 0x1 lowest, 0x0 never arbitrates.
// (RQ23) irq_source_select middle bit enables gate-event interrupts.
module timer_bypass_top
  import timer_bypass_pkg::*;
(
  input wire logic clk_i, // 50 MHz system clock
  input wire logic rstn_i, // async hardware reset, low
  input wire logic soft_rst_i, // reset instruction pulse
  input wire logic debug_halt_i, // freeze request
  input wire logic [11:0] module_base_i, // module_base_reg address bits
  input wire logic cyc_i, // bus cycle strobe
  input wire logic we_i, // write
  input wire logic super_i, // supervisor access
  input wire logic [23:0] addr_i, // byte address
  input wire logic [1:0] be_i, // byte enables
  input wire logic [15:0] wdata_i, // write data
  input wire logic iack_i, // interrupt acknowledge cycle
  input wire logic [2:0] iack_level_i, // level acknowledged
  input wire logic [3:0] arb_in_i, // best competing arbitration id
  input wire logic [1:0] gate_input_n_i, // gate pins, active low
  input wire logic [1:0] timer_output_i, // timer_output pin levels
  output logic [1:0] timer_output_o, // timer_output drive value
  output logic [1:0] timer_output_oe_o, // timer_output enable
  output logic [2:0] irq_request_o, // requested level
  output logic [3:0] arb_id_o, // our arbitration id while requesting
  output logic ack_o, // cycle done
  output logic berr_o, // bus error
  output logic [15:0] rdata_o // read data / vector
);
  logic rst_meta_reg;
  logic rst_n;
  logic [15:0] mcr_reg;
  logic [1:0] gate_sync;
  logic [1:0] pin_sync;
  logic [1:0] inst_hit;
  logic [5:0] ofs;
  logic mcr_hit;
  logic priv_ok;
  logic stopped;
  logic run;
  logic [1:0] ch_wr;
  logic [15:0] ch_ctrl [2];
  logic [15:0] ch_ivr [2];
  logic [15:0] ch_stat [2];
  logic [1:0] ch_irq;
  logic sel;
  logic [15:0] rd_val;
  logic [2:0] lvl0;
  logic [2:0] lvl1;
  logic [1:0] win;
  bus_state_e bus_state;

  //////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      rst_meta_reg <= 1'b0;
      rst_n <= 1'b0;
    end
    else
    begin
      rst_meta_reg <= 1'b1;
      rst_n <= rst_meta_reg;
    end
  end

  gate_sync #(.WIDTH(2)) u_gate_sync (
    .clk_i(clk_i),
    .rst_n_i(rst_n),
    .d_i(gate_input_n_i),
    .q_o(gate_sync)
  );
  gate_sync #(.WIDTH(2)) u_pin_sync (
    .clk_i(clk_i),
    .rst_n_i(rst_n),
    .d_i(timer_output_i),
    .q_o(pin_sync)
  );

  //////////////////////////////////////////////////////////////////////////////
  // decode: a 16-bit register file sits behind each instance base
  assign ofs = addr_i[5:0];
  always_comb
  begin
    inst_hit = 2'b00;
    if (addr_i[23:12] == module_base_i && addr_i[11:6] == TIMER0_BASE[11:6])
      inst_hit[0] = 1'b1; // RQ15
    if (addr_i[23:12] == module_base_i && addr_i[11:6] == TIMER1_BASE[11:6])
      inst_hit[1] = 1'b1; // RQ15
  end
  assign sel = inst_hit[1];
  assign mcr_hit = ofs[5:1] == OFS_MCR[5:1];
  // control and status are supervisor/user; module config and vector supervisor only
  assign priv_ok = super_i || ((ofs == OFS_CTRL || ofs == OFS_STAT)
                              && !mcr_reg[MCR_USER_ACCESS_LOCK]); // RQ16
  assign stopped = mcr_reg[MCR_STP];
  // stop and freeze both hold the channel logic still; the bus side keeps running
  assign run = !stopped && !(debug_halt_i && mcr_reg[MCR_FRZ1]); // RQ18 RQ21

  //////////////////////////////////////////////////////////////////////////////
  // shared module config lives at the first instance's offset 0x600
  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
      mcr_reg <= MCR_RESET;
    else if (cyc_i && we_i && inst_hit[0] && mcr_hit && super_i
             && bus_state == BUS_IDLE && !iack_i)
      mcr_reg <= (mcr_reg & ~({{8{be_i[1]}}, {8{be_i[0]}}} & MCR_WMASK))
                 | (wdata_i & {{8{be_i[1]}}, {8{be_i[0]}}} & MCR_WMASK); // RQ12
  end

  generate
    for (genvar i = 0; i < 2; i++)
    begin : g_ch
      assign ch_wr[i] = cyc_i && we_i && !iack_i && inst_hit[i] && priv_ok && !stopped
                        && bus_state == BUS_IDLE;
      timer_channel u_ch (
        .clk_i(clk_i),
        .rst_n_i(rst_n),
        .soft_rst_i(soft_rst_i), // RQ17
        .run_i(run),
        .wr_i(ch_wr[i]),
        .ofs_i(ofs),
        .wdata_i(wdata_i),
        .be_i(be_i),
        .gate_level_i(gate_sync[i]),
        .out_pin_i(pin_sync[i]),
        .ctrl_o(ch_ctrl[i]),
        .ivr_o(ch_ivr[i]),
        .status_o(ch_stat[i]),
        .irq_o(ch_irq[i]),
        .out_drive_o(timer_output_o[i]),
        .out_oe_o(timer_output_oe_o[i])
      );
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////////
  // interrupt request and acknowledge arbitration
  assign lvl0 = ch_irq[0] ? ch_ivr[0][10:8] : 3'h0;
  assign lvl1 = ch_irq[1] ? ch_ivr[1][10:8] : 3'h0;
  assign irq_request_o = lvl0 > lvl1 ? lvl0 : lvl1;
  // both instances share one id; instance 0 breaks the internal tie
  assign win[0] = lvl0 != 3'h0 && lvl0 == iack_level_i;
  assign win[1] = !win[0] && lvl1 != 3'h0 && lvl1 == iack_level_i;
  assign arb_id_o = (irq_request_o != 3'h0) ? mcr_reg[3:0] : 4'h0; // RQ22

  always_comb
  begin
    rd_val = 16'h0000; // RQ11
    if (inst_hit[0] && mcr_hit)
      rd_val = mcr_reg;
    else if (inst_hit != 2'b00)
    begin
      case (ofs)
        OFS_IVR: rd_val = ch_ivr[sel];
        OFS_CTRL: rd_val = ch_ctrl[sel];
        OFS_STAT: rd_val = ch_stat[sel];
        default: rd_val = 16'h0000; // RQ11
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // one-cycle answer: ack or berr in the cycle after the strobe
  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      bus_state <= BUS_IDLE;
      rdata_o <= 16'h0000;
    end
    else
    begin
      case (bus_state)
        BUS_IDLE:
        begin
          if (cyc_i && iack_i)
          begin
            // id 0 never takes part; a higher outside id wins
            if (mcr_reg[3:0] != 4'h0 && win != 2'b00 && mcr_reg[3:0] >= arb_in_i) // RQ22
            begin
              bus_state <= BUS_ACK;
              rdata_o <= {8'h00, ch_ivr[win[1]][7:0]}; // RQ13
            end
          end
          else if (cyc_i && inst_hit != 2'b00)
          begin
            if ((stopped && !(inst_hit[0] && mcr_hit)) || !priv_ok
                || (inst_hit[0] && mcr_hit && !super_i))
              bus_state <= BUS_BERR; // RQ19 RQ16
            else
            begin
              bus_state <= BUS_ACK; // RQ10 RQ12
              rdata_o <= we_i ? 16'h0000 : rd_val;
            end
          end
        end
        BUS_ACK: bus_state <= BUS_IDLE;
        BUS_BERR: bus_state <= BUS_IDLE;
        default: bus_state <= BUS_IDLE;
      endcase
    end
  end
  assign ack_o = bus_state == BUS_ACK;
  assign berr_o = bus_state == BUS_BERR;

  a_stop_berr: assert property (@(posedge clk_i) disable iff (!rst_n) // RQ19
    bus_state == BUS_IDLE && cyc_i && !iack_i && stopped && inst_hit[1] |=> berr_o)
    else $error("stopped access not refused");
  // the pin itself, two synchroniser edges back, so a broken status path is caught
  a_tgl_level: assert property (@(posedge clk_i) disable iff (!rst_n) // RQ3
    ch_stat[0][SR_TGL] == $past(gate_input_n_i[0], 2))
    else $error("gate level not reported");
  a_pre_ones: assert property (@(posedge clk_i) disable iff (!rst_n) // RQ8
    ch_stat[1][7:0] == 8'hFF && ch_stat[1][SR_TO] == 1'b0)
    else $error("status idle fields wrong");
  a_read_ack: assert property (@(posedge clk_i) disable iff (!rst_n) // RQ10
    bus_state == BUS_IDLE && cyc_i && !iack_i && !we_i && inst_hit[0] && mcr_hit && super_i
    |=> ack_o && rdata_o == $past(mcr_reg))
    else $error("config read not answered next cycle");
  a_no_arb0: assert property (@(posedge clk_i) disable iff (!rst_n) // RQ22
    bus_state == BUS_IDLE && cyc_i && iack_i && mcr_reg[3:0] == 4'h0 |=> !ack_o)
    else $error("arbitrated with id zero");
  a_out_hiz: assert property (@(posedge clk_i) disable iff (!rst_n) // RQ7
    run && ch_ctrl[0][4:2] == MODE_BYPASS && ch_ctrl[0][CR_CPE] && !ch_ctrl[0][CR_SWR]
    && ch_ctrl[0][1:0] == 2'b00 && !soft_rst_i |=> !timer_output_oe_o[0])
    else $error("output not released");
  a_out_high: assert property (@(posedge clk_i) disable iff (!rst_n) // RQ7
    run && ch_ctrl[1][4:2] == MODE_BYPASS && ch_ctrl[1][CR_CPE] && !ch_ctrl[1][CR_SWR]
    && ch_ctrl[1][1:0] == 2'b11 && !soft_rst_i |=> timer_output_oe_o[1] && timer_output_o[1])
    else $error("output not driven high");
  a_mcr_keep: assert property (@(posedge clk_i) disable iff (!rst_n) // RQ17
    soft_rst_i && !(cyc_i && we_i) |=> mcr_reg == $past(mcr_reg) && ch_ivr[0] == IVR_RESET)
    else $error("reset instruction handling wrong");
  a_stop_hold: assert property (@(posedge clk_i) disable iff (!rst_n) // RQ18
    stopped && !soft_rst_i |=> $stable(ch_stat[0][SR_TG]) && $stable(ch_stat[0][SR_ON]))
    else $error("channel moved while stopped");
endmodule : timer_bypass_top

// ### rtl/timer_bypass_pkg.sv
package timer_bypass_pkg;
  // instance bases from module_base_reg; register offsets from the instance base
  localparam logic [11:0] TIMER0_BASE = 12'h600;
  localparam logic [11:0] TIMER1_BASE = 12'h640;
  localparam logic [5:0] OFS_MCR = 6'h00;
  localparam logic [5:0] OFS_IVR = 6'h04;
  localparam logic [5:0] OFS_CTRL = 6'h06;
  localparam logic [5:0] OFS_STAT = 6'h08;
  // control_reg fields
  localparam int CR_SWR = 15;
  localparam int CR_IE_HI = 14;
  localparam int CR_IE_GATE = 13;
  localparam int CR_TGE = 11;
  localparam int CR_CPE = 9;
  localparam int CR_MODE_LO = 2;
  localparam logic [2:0] MODE_BYPASS = 3'h7;
  // module_config_reg fields; module_config_reg, irq_vector_reg and control_reg reset values, module_config_reg and irq_vector_reg write masks
  localparam int MCR_STP = 15;
  localparam int MCR_FRZ1 = 14;
  localparam int MCR_USER_ACCESS_LOCK = 7;
  localparam logic [15:0] MCR_RESET = 16'h0080;
  localparam logic [15:0] MCR_WMASK = 16'hE08F;
  localparam logic [15:0] IVR_RESET = 16'h000F;
  localparam logic [15:0] IVR_WMASK = 16'h07FF;
  localparam logic [15:0] CR_RESET = 16'h0000;
  // status_reg fields
  localparam int SR_IRQ = 15;
  localparam int SR_TO = 14;
  localparam int SR_TG = 13;
  localparam int SR_TC = 12;
  localparam int SR_TGL = 11;
  localparam int SR_ON = 10;
  localparam int SR_OUT = 9;
  localparam int SR_COM = 8;
  localparam logic [7:0] PRESCALER_IDLE = 8'hFF;
  // bus phases
  typedef enum logic [1:0] {
    BUS_IDLE = 2'b00,
    BUS_ACK = 2'b01,
    BUS_BERR = 2'b10
  } bus_state_e;
endpackage : timer_bypass_pkg

// ### rtl/gate_sync.sv
`timescale 1ns/10ps
// two-stage synchroniser for pin inputs
module gate_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk_i, // clock
  input wire logic rst_n_i, // synced reset
  input wire logic [WIDTH-1:0] d_i, // async input
  output logic [WIDTH-1:0] q_o // synced output
);
  logic [WIDTH-1:0] meta_reg;
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      // pins idle high: resetting to that level avoids a false edge after reset
      meta_reg <= '1;
      q_o <= '1;
    end
    else
    begin
      meta_reg <= d_i;
      q_o <= meta_reg;
    end
  end
endmodule : gate_sync

// ### rtl/timer_channel.sv
`timescale 1ns/10ps
// one bypass-mode timer channel: control, status and interrupt registers
module timer_channel
  import timer_bypass_pkg::*;
(
  input wire logic clk_i, // clock
  input wire logic rst_n_i, // synced reset
  input wire logic soft_rst_i, // reset-instruction pulse
  input wire logic run_i, // module clock running
  input wire logic wr_i, // write strobe
  input wire logic [5:0] ofs_i, // register offset
  input wire logic [15:0] wdata_i, // write data
  input wire logic [1:0] be_i, // byte enables, [1]=hi
  input wire logic gate_level_i, // synced gate pin level
  input wire logic out_pin_i, // synced timer_output pin level
  output logic [15:0] ctrl_o, // control_reg
  output logic [15:0] ivr_o, // irq_vector_reg
  output logic [15:0] status_o, // status_reg read value
  output logic irq_o, // interrupt request level
  output logic out_drive_o, // timer_output value
  output logic out_oe_o // timer_output enable
);
  logic [15:0] ctrl_reg;
  logic [15:0] ivr_reg;
  logic gate_event_reg;
  logic on_reg;
  logic gate_d_reg;
  logic bypass;
  logic rise;
  logic tg_clr;
  assign bypass = ctrl_reg[CR_MODE_LO+2:CR_MODE_LO] == MODE_BYPASS; // RQ1
  assign rise = gate_level_i & ~gate_d_reg;
  assign tg_clr = wr_i && ofs_i == OFS_STAT && be_i[1] && wdata_i[SR_TG]; // RQ5
  function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] nw,
                                        input logic [1:0] be, input logic [15:0] msk);
    logic [15:0] lanes;
    lanes = {{8{be[1]}}, {8{be[0]}}} & msk;
    merge = (old & ~lanes) | (nw & lanes);
  endfunction : merge
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      ctrl_reg <= CR_RESET;
      ivr_reg <= IVR_RESET;
    end
    else if (soft_rst_i) // RQ17
    begin
      ctrl_reg <= CR_RESET;
      ivr_reg <= IVR_RESET;
    end
    else if (wr_i)
    begin
      if (ofs_i == OFS_CTRL)
        ctrl_reg <= merge(ctrl_reg, wdata_i, be_i, 16'hFFFF);
      if (ofs_i == OFS_IVR)
        ivr_reg <= merge(ivr_reg, wdata_i, be_i, IVR_WMASK); // RQ12
    end
  end
  // gate pin is active low: gate asserted when level is 0
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      gate_d_reg <= 1'b1;
      on_reg <= 1'b0;
      gate_event_reg <= 1'b0;
    end
    else if (soft_rst_i)
    begin
      gate_d_reg <= 1'b1;
      on_reg <= 1'b0;
      gate_event_reg <= 1'b0;
    end
    else
    begin
      gate_d_reg <= gate_level_i;
      // frozen or stopped: running and event flags hold except by software; gate_d_reg keeps tracking the pin
      if (run_i)
        on_reg <= bypass && ctrl_reg[CR_CPE] && !ctrl_reg[CR_IE_GATE] && !gate_level_i; // RQ2
      // set wins over a simultaneous clear
      if (run_i && bypass && ctrl_reg[CR_IE_GATE] && ctrl_reg[CR_TGE] && ctrl_reg[CR_CPE]
          && rise)
        gate_event_reg <= 1'b1; // RQ4
      else if (tg_clr)
        gate_event_reg <= 1'b0; // RQ5
    end
  end
  // output: only follows output_control while soft_reset_release is clear
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      out_drive_o <= 1'b0;
      out_oe_o <= 1'b0;
    end
    else if (soft_rst_i)
    begin
      out_drive_o <= 1'b0;
      out_oe_o <= 1'b0;
    end
    else if (run_i && bypass && ctrl_reg[CR_CPE] && !ctrl_reg[CR_SWR]) // RQ6
    begin
      out_oe_o <= ctrl_reg[1:0] != 2'b00; // RQ7
      out_drive_o <= ctrl_reg[1:0] == 2'b11; // RQ7
    end
  end
  assign irq_o = gate_event_reg && ctrl_reg[CR_IE_GATE] && ivr_reg[10:8] != 3'h0; // RQ23
  always_comb
  begin
    status_o = 16'h0000;
    status_o[SR_IRQ] = irq_o;
    status_o[SR_TG] = gate_event_reg;
    status_o[SR_TGL] = gate_level_i; // RQ3
    status_o[SR_ON] = on_reg;
    status_o[SR_OUT] = out_pin_i; // RQ9
    status_o[SR_TO] = 1'b0; // RQ8
    status_o[SR_TC] = 1'b0;
    status_o[SR_COM] = 1'b0;
    status_o[7:0] = PRESCALER_IDLE; // RQ8
  end
  assign ctrl_o = ctrl_reg;
  assign ivr_o = ivr_reg;
endmodule : timer_channel

// ### dv/host_model.sv
`timescale 1ns/10ps
// bus master standing in for the host processor on the internal module bus
module host_model (
  input wire logic clk_i, // clock
  input wire logic ack_i, // cycle done
  input wire logic berr_i, // bus error
  input wire logic [15:0] rdata_i, // read data or vector
  output logic cyc_o, // cycle strobe
  output logic we_o, // write
  output logic super_o, // supervisor access
  output logic [23:0] addr_o, // byte address
  output logic [1:0] be_o, // byte lanes
  output logic [15:0] wdata_o, // write data
  output logic iack_o, // acknowledge cycle
  output logic [2:0] iack_level_o // level acknowledged
);
  initial
  begin
    cyc_o = 1'b0;
    we_o = 1'b0;
    super_o = 1'b0;
    addr_o = 24'h00_0000;
    be_o = 2'b00;
    wdata_o = 16'h0000;
    iack_o = 1'b0;
    iack_level_o = 3'h0;
  end

  //////////////////////////////////////////////////////////////////////////////
  // resp: 0 no answer within the bound, 1 ack, 2 bus error
  // the request is held until the edge that sees the answer, so a slow device is met too
  task automatic access(input logic we, input logic sup, input logic [23:0] addr,
      input logic [1:0] be, input logic [15:0] wd, input logic iack, input logic [2:0] lvl,
      output logic [15:0] rd, output logic [1:0] resp);
    int n;
    rd = 16'h0000;
    resp = 2'd0;
    @(posedge clk_i);
    cyc_o <= 1'b1;
    we_o <= we;
    super_o <= sup;
    addr_o <= addr;
    be_o <= be;
    wdata_o <= wd;
    iack_o <= iack;
    iack_level_o <= lvl;
    for (n = 0; n < 6 && resp == 2'd0; n++)
    begin
      @(posedge clk_i);
      if (ack_i === 1'b1)
      begin
        resp = 2'd1;
        rd = rdata_i;
      end
      else if (berr_i === 1'b1)
        resp = 2'd2;
    end
    cyc_o <= 1'b0;
    iack_o <= 1'b0;
  endtask : access
endmodule : host_model

// ### dv/testbench.sv
`timescale 1ns/10ps
module testbench;
  import timer_bypass_pkg::*;
  localparam logic [11:0] BASE = 12'h0a5;
  logic clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic soft_rst_i = 1'b0;
  logic debug_halt_i = 1'b0;
  logic [3:0] arb_in_i = 4'h0;
  logic [1:0] gate_n = 2'b11;
  logic cyc, we, sup, iack, ack, berr;
  logic [2:0] lvl, irq;
  logic [23:0] addr;
  logic [1:0] be, out_drv, out_oe, pin;
  logic [15:0] wdata, rdata;
  logic [3:0] arb_id;
  int n_fail = 0;
  int checks_done = 0;

  always #10 clk_i = ~clk_i;
  // board pull-up: an undriven output pin reads high
  assign pin = (out_drv & out_oe) | ~out_oe;

  timer_bypass_top dut (.clk_i(clk_i), .rstn_i(rstn_i), .soft_rst_i(soft_rst_i),
    .debug_halt_i(debug_halt_i), .module_base_i(BASE), .cyc_i(cyc), .we_i(we), .super_i(sup),
    .addr_i(addr), .be_i(be), .wdata_i(wdata), .iack_i(iack), .iack_level_i(lvl),
    .arb_in_i(arb_in_i), .gate_input_n_i(gate_n), .timer_output_i(pin),
    .timer_output_o(out_drv), .timer_output_oe_o(out_oe), .irq_request_o(irq),
    .arb_id_o(arb_id), .ack_o(ack), .berr_o(berr), .rdata_o(rdata));
  host_model host (.clk_i(clk_i), .ack_i(ack), .berr_i(berr), .rdata_i(rdata), .cyc_o(cyc),
    .we_o(we), .super_o(sup), .addr_o(addr), .be_o(be), .wdata_o(wdata), .iack_o(iack),
    .iack_level_o(lvl));

  //////////////////////////////////////////////////////////////////////////////
  task automatic end_of_test;
    $display("comparisons %0d, mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : end_of_test

  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
    checks_done++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("wrong value at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : check

  function automatic logic [15:0] stat(input logic irq_f, tg, tgl, on, out);
    return {irq_f, 1'b0, tg, 1'b0, tgl, on, out, 1'b0, 8'hff};
  endfunction : stat

  // a missing answer where one is due ends the run
  task automatic acc(input logic wr_f, input logic sup_f, input logic [11:0] off,
      input logic [1:0] lanes, input logic [15:0] wd, input logic [1:0] exp_resp,
      input logic [15:0] exp_rd);
    logic [15:0] rd_v;
    logic [1:0] resp;
    host.access(wr_f, sup_f, {BASE, off}, lanes, wd, 1'b0, 3'h0, rd_v, resp);
    check({14'h0, resp}, {14'h0, exp_resp}, "bus answer");
    if (wr_f === 1'b0 && exp_resp === 2'd1)
      check(rd_v, exp_rd, "read data");
    if (resp === 2'd0 && exp_resp !== 2'd0)
      end_of_test();
  endtask : acc

  task automatic wr(input logic [11:0] off, input logic [15:0] wd);
    acc(1'b1, 1'b1, off, 2'b11, wd, 2'd1, 16'h0000);
  endtask : wr

  task automatic rd(input logic [11:0] off, input logic [15:0] exp);
    acc(1'b0, 1'b1, off, 2'b11, 16'h0000, 2'd1, exp);
  endtask : rd

  // five edges cover the two-flop pin synchroniser and the status register
  task automatic gate(input logic v);
    @(posedge clk_i);
    gate_n[0] <= v;
    repeat (5) @(posedge clk_i);
  endtask : gate

  task automatic ack_cycle(input logic [3:0] other, input logic [1:0] exp_resp,
      input logic [15:0] exp_vec);
    logic [15:0] rd_v;
    logic [1:0] resp;
    @(posedge clk_i);
    arb_in_i <= other;
    host.access(1'b0, 1'b1, {BASE, 12'h000}, 2'b11, 16'h0000, 1'b1, 3'h3, rd_v, resp);
    check({14'h0, resp}, {14'h0, exp_resp}, "acknowledge answer");
    if (exp_resp === 2'd1)
      check({8'h00, rd_v[7:0]}, exp_vec, "vector");
  endtask : ack_cycle

  //////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    rd(12'h600, 16'h0080);
    rd(12'h604, 16'h000f);
    rd(12'h606, 16'h0000);
    rd(12'h60a, 16'h0000);
    acc(1'b0, 1'b1, 12'h680, 2'b11, 16'h0000, 2'd0, 16'h0000);
    $display("test reset done");
  endtask : t_reset

  task automatic t_input;
    wr(12'h606, 16'h021c);
    gate(1'b0);
    rd(12'h608, stat(0, 0, 0, 1, 1));
    gate(1'b1);
    rd(12'h608, stat(0, 0, 1, 0, 1));
    wr(12'h608, 16'h00ff);
    rd(12'h608, stat(0, 0, 1, 0, 1));
    $display("test input done");
  endtask : t_input

  task automatic t_irq;
    wr(12'h604, 16'h0340);
    wr(12'h600, 16'h0085);
    wr(12'h606, 16'h2a1c);
    gate(1'b0);
    gate(1'b1);
    check({13'h0, irq}, 16'h0003, "irq level");
    check({12'h0, arb_id}, 16'h0005, "arbitration id");
    wr(12'h608, 16'h0000);
    rd(12'h608, stat(1, 1, 1, 0, 1));
    ack_cycle(4'h4, 2'd1, 16'h0040);
    ack_cycle(4'h6, 2'd0, 16'h0000);
    wr(12'h608, 16'h2000);
    rd(12'h608, stat(0, 0, 1, 0, 1));
    check({13'h0, irq}, 16'h0000, "irq dropped");
    wr(12'h600, 16'h0080);
    gate(1'b0);
    gate(1'b1);
    ack_cycle(4'h0, 2'd0, 16'h0000);
    wr(12'h608, 16'h2000);
    $display("test irq done");
  endtask : t_irq

  task automatic t_output;
    for (int oc = 0; oc < 4; oc++)
    begin
      wr(12'h606, 16'h021c | 16'(oc));
      repeat (5) @(posedge clk_i);
      check({15'h0, out_oe[0]}, {15'h0, oc != 0}, "output enable");
      if (oc != 0)
        check({15'h0, out_drv[0]}, {15'h0, oc == 3}, "output level");
      rd(12'h608, stat(0, 0, 1, 0, oc == 0 || oc == 3));
    end
    wr(12'h606, 16'h821c);
    repeat (5) @(posedge clk_i);
    check({14'h0, out_oe[0], out_drv[0]}, 16'h0003, "output held");
    $display("test output done");
  endtask : t_output

  task automatic t_freeze;
    logic [15:0] rd_v;
    logic [1:0] resp;
    wr(12'h606, 16'h021c);
    wr(12'h600, 16'h4080);
    @(posedge clk_i);
    debug_halt_i <= 1'b1;
    gate(1'b0);
    host.access(1'b0, 1'b1, {BASE, 12'h608}, 2'b11, 16'h0000, 1'b0, 3'h0, rd_v, resp);
    check(rd_v & 16'h0400, 16'h0000, "frozen running flag");
    wr(12'h600, 16'h2080);
    gate(1'b0);
    host.access(1'b0, 1'b1, {BASE, 12'h608}, 2'b11, 16'h0000, 1'b0, 3'h0, rd_v, resp);
    check(rd_v & 16'h0400, 16'h0400, "running flag free");
    @(posedge clk_i);
    debug_halt_i <= 1'b0;
    gate(1'b1);
    $display("test freeze done");
  endtask : t_freeze

  task automatic t_access;
    wr(12'h606, 16'h0000);
    acc(1'b1, 1'b1, 12'h606, 2'b01, 16'h55e3, 2'd1, 16'h0000);
    acc(1'b1, 1'b1, 12'h606, 2'b10, 16'h02ff, 2'd1, 16'h0000);
    rd(12'h606, 16'h02e3);
    acc(1'b0, 1'b0, 12'h600, 2'b11, 16'h0000, 2'd2, 16'h0000);
    acc(1'b0, 1'b0, 12'h606, 2'b11, 16'h0000, 2'd2, 16'h0000);
    wr(12'h600, 16'h0000);
    acc(1'b0, 1'b0, 12'h606, 2'b11, 16'h0000, 2'd1, 16'h02e3);
    wr(12'h606, 16'h0000);
    wr(12'h600, 16'h8080);
    acc(1'b0, 1'b1, 12'h606, 2'b11, 16'h0000, 2'd2, 16'h0000);
    acc(1'b1, 1'b1, 12'h646, 2'b11, 16'h021f, 2'd2, 16'h0000);
    rd(12'h600, 16'h8080);
    wr(12'h600, 16'h0080);
    wr(12'h646, 16'h021f);
    rd(12'h646, 16'h021f);
    rd(12'h606, 16'h0000);
    repeat (3) @(posedge clk_i);
    check({14'h0, out_oe[1], out_drv[1]}, 16'h0003, "second output");
    $display("test access done");
  endtask : t_access

  task automatic t_soft;
    wr(12'h604, 16'h0355);
    wr(12'h600, 16'h0083);
    @(posedge clk_i);
    soft_rst_i <= 1'b1;
    @(posedge clk_i);
    soft_rst_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    rd(12'h604, 16'h000f);
    rd(12'h646, 16'h0000);
    rd(12'h600, 16'h0083);
    check({15'h0, out_oe[1]}, 16'h0000, "second output released");
    $display("test soft reset done");
  endtask : t_soft

  //////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (6) @(posedge clk_i);
    rstn_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    t_reset();
    t_input();
    t_irq();
    t_output();
    t_freeze();
    t_access();
    t_soft();
    end_of_test();
  end

  initial
  begin
    #1000000;
    n_fail++;
    end_of_test();
  end
endmodule : testbench
